/* fsq_flash_model.sv */
// flash array model: busy for a while after each command
`timescale 1ns/10ps
module fsq_flash_model
	import fsq_pkg::*;
#(
	parameter logic [1:0] SLOW = 2'h2
) (
	input wire logic           core_clk,
	input wire logic           rst_b,
	input wire fsq_flash_cmd_t flash_cmd,
	output logic               flash_busy
);
	logic [1:0] busy_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) busy_q <= 2'h0;
		else if (flash_cmd.req) busy_q <= SLOW;
		else if (busy_q != 2'h0) busy_q <= busy_q - 2'h1;
	end
	assign flash_busy = busy_q != 2'h0;
endmodule

/* fsq_pkg.sv */
// package for the flash self erase/write sequencer
package fsq_pkg;
	localparam logic [7:0]  FSQ_OFF_CTRL    = 8'h00;
	localparam logic [7:0]  FSQ_OFF_KEY     = 8'h04;
	localparam logic [7:0]  FSQ_OFF_PTR     = 8'h08;
	localparam logic [7:0]  FSQ_OFF_LATCH   = 8'h0C;
	localparam logic [7:0]  FSQ_OFF_TBLOP   = 8'h10;
	localparam logic [7:0]  FSQ_OFF_STATUS  = 8'h14;
	localparam int          FSQ_CTRL_START  = 0;
	localparam int          FSQ_CTRL_PROGRAM_WRITE_ENABLE   = 1;
	localparam int          FSQ_CTRL_ERASE  = 2;
	localparam int          FSQ_CTRL_CFG    = 3;
	localparam int          FSQ_CTRL_PGM    = 4;
	localparam int          FSQ_CTRL_ERR    = 5;
	localparam logic [7:0]  FSQ_KEY_FIRST   = 8'h55;
	localparam logic [7:0]  FSQ_KEY_SECOND  = 8'hAA;
	localparam logic [7:0]  FSQ_HOLD_RESET  = 8'hFF;
	localparam int          FSQ_ERASE_BYTES = 64;
	localparam int          FSQ_ERASE_LSB   = 6;
	localparam int          FSQ_PTR_W       = 22;
	localparam int          FSQ_PTR_MOD_W   = 21;
	localparam int          FSQ_BLOCK_BYTES = 16;
	localparam int          FSQ_CLK_HZ      = 20_000_000;
	localparam int          FSQ_LONG_US     = 2000;
	localparam int          FSQ_LONG_CYC    = FSQ_LONG_US * (FSQ_CLK_HZ / 1_000_000);
	localparam logic [1:0]  FSQ_OP_HOLD     = 2'h0;
	localparam logic [1:0]  FSQ_OP_POSTINC  = 2'h1;
	localparam logic [1:0]  FSQ_OP_POSTDEC  = 2'h2;
	localparam logic [1:0]  FSQ_OP_PREINC   = 2'h3;
	typedef enum logic [1:0] {FSQ_IDLE, FSQ_ERASE, FSQ_PROG, FSQ_DONE} fsq_state_t;
	typedef enum logic [1:0] {FSQ_KEY_NONE, FSQ_KEY_HALF, FSQ_KEY_ARMED} fsq_key_t;
	typedef struct packed {
		logic        req;
		logic        erase;
		logic [21:0] addr;
		logic [7:0]  wdata;
		logic [15:0] bmask;
	} fsq_flash_cmd_t;
endpackage

/* fsq_props.sv */
// port checker for the flash sequencer
`timescale 1ns/10ps
module fsq_props
	import fsq_pkg::*;
#(
	parameter int LONG_CYC = 50
) (
	input wire logic           core_clk,
	input wire logic           rst_b,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [7:0]     paddr,
	input wire logic [31:0]    pwdata,
	input wire logic           pready,
	input wire logic [31:0]    prdata,
	input wire logic           pslverr,
	input wire logic           flash_busy,
	input wire fsq_flash_cmd_t flash_cmd,
	input wire logic           cpu_stall
);
	logic [31:0] cnt_q;
	logic        start_wr;
	assign start_wr = psel && penable && pwrite && paddr == FSQ_OFF_CTRL && pwdata[FSQ_CTRL_START];
	// length of the current stall
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) cnt_q <= '0;
		else cnt_q <= cpu_stall ? cnt_q + 32'h0000_0001 : '0;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_STALL_RDY: assert property (cpu_stall |-> !pready) else $error("ready in stall");
	AST_IDLE_RDY: assert property (!cpu_stall |-> pready) else $error("wait when idle");
	AST_REQ_STALL: assert property (flash_cmd.req |-> cpu_stall) else $error("req outside stall");
	AST_ERA_ADDR: assert property (flash_cmd.req && flash_cmd.erase |-> flash_cmd.addr[5:0] == 6'h00) else $error("erase addr");
	AST_FF_SKIP: assert property (flash_cmd.req && !flash_cmd.erase |-> flash_cmd.wdata != 8'hFF) else $error("ff byte");
	AST_START: assert property ($rose(cpu_stall) |-> $past(start_wr)) else $error("stall w/o start");
	AST_LEN: assert property ($fell(cpu_stall) |-> cnt_q == LONG_CYC + 1) else $error("stall length");
	AST_ERA_CMD: assert property ($rose(cpu_stall) && $past(pwdata[2]) |-> ##[0:2] (flash_cmd.req && flash_cmd.erase)) else $error("no erase");
	C_ERASE: cover property (flash_cmd.req && flash_cmd.erase);
	C_PROG: cover property (flash_cmd.req && !flash_cmd.erase);
	C_FALL: cover property ($fell(cpu_stall));
endmodule
bind fsq_sequencer fsq_props #(.LONG_CYC(LONG_CYC)) i_fsq_props (.core_clk, .rst_b, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .prdata, .pslverr, .flash_busy, .flash_cmd, .cpu_stall);

/* fsq_sequencer.sv */
// flash self erase/write sequencer with apb register slave
`timescale 1ns/10ps
// Behaviour
// R1 - self erase clears one whole 64 byte block
// R2 - no single word erase; every erase acts on a block
// R3 - bulk erase is not reachable from this block
// R4 - erase block chosen by pointer bits 21:6, bits 5:0 ignored
// R5 - software sets program select, write enable and erase select first
// R6 - software clears config select for program memory operations
// R7 - long write starts only after 55h then AAh key then start bit
// R8 - cpu stalled during long write; timer ends the cycle
// R9 - erase stalls cpu about 2 ms
// R10 - programming acts on whole write blocks of 8 or 16 bytes
// R11 - table writes only load holding registers, one per block byte
// R12 - program long write writes the whole holding block to flash
// R13 - program cycle stalls cpu about 2 ms
// R14 - holding registers return to FFh on reset and after each write
// R15 - FFh holding byte leaves flash byte unchanged; only clears bits
// R16 - partial holding loads allowed; unloaded bytes untouched
// R17 - software keeps pointer within the holding block range
// R18 - software update flow: read, erase, write blocks, verify
// R19 - whole update takes about 6 ms per write block
// R20 - table write picks holding register from low pointer bits
// R21 - program write uses upper pointer bits, ignores low bits
// R22 - table ops hold, post inc, post dec or pre inc low 21 bits
// R23 - start ignored without write enable or fresh key sequence
// R24 - erase select clear means program from holding registers
module fsq_sequencer
	import fsq_pkg::*;
#(
	parameter int BLOCK_BYTES = FSQ_BLOCK_BYTES,
	parameter int LONG_CYC    = FSQ_LONG_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        flash_busy,
	output fsq_flash_cmd_t   flash_cmd,
	output logic             cpu_stall
);
	localparam int IDX_W = $clog2(BLOCK_BYTES);
	localparam int CNT_W = $clog2(LONG_CYC + 1);
	localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYC - 1);

	typedef struct packed {
		fsq_state_t                    state;
		fsq_key_t                      key;
		logic                          pgm;
		logic                          cfg;
		logic                          program_write_enable;
		logic                          erase;
		logic                          start;
		logic                          err;
		logic [FSQ_PTR_W-1:0]          ptr;
		logic [7:0]                    latch;
		logic [BLOCK_BYTES-1:0][7:0]   hold;
		logic [CNT_W-1:0]              cnt;
		logic [IDX_W:0]                idx;
		logic                          ops_done;
		fsq_flash_cmd_t                cmd;
		logic [31:0]                   rdata;
	} fsq_regs_t;

	fsq_regs_t q;
	fsq_regs_t d;

	logic            acc;
	logic            wr_acc;
	logic            rd_acc;
	logic            mapped;
	logic [FSQ_PTR_W-1:0] ptr_inc;
	logic [FSQ_PTR_W-1:0] ptr_dec;
	logic [IDX_W-1:0] hsel;

	assign acc     = psel & penable;
	assign wr_acc  = acc & pwrite;
	assign rd_acc  = acc & ~pwrite;
	assign mapped  = (paddr == FSQ_OFF_CTRL) | (paddr == FSQ_OFF_KEY) | (paddr == FSQ_OFF_PTR) |
			 (paddr == FSQ_OFF_LATCH) | (paddr == FSQ_OFF_TBLOP) | (paddr == FSQ_OFF_STATUS);
	// only the low 21 bits step; bit 21 keeps its value
	assign ptr_inc = {q.ptr[21], q.ptr[20:0] + 21'h00_0001}; // [R22]
	assign ptr_dec = {q.ptr[21], q.ptr[20:0] - 21'h00_0001}; // [R22]

	// the bus is answered at once except while the cpu is stalled
	assign pready    = ~cpu_stall;
	assign pslverr   = acc & ~mapped;
	assign prdata    = q.rdata;
	assign cpu_stall = (q.state != FSQ_IDLE); // [R8]
	assign flash_cmd = q.cmd;

	always_comb begin
		d       = q;
		hsel    = '0;
		d.cmd.req = 1'b0;
		unique case (q.state)
			FSQ_IDLE: begin
				if (wr_acc && mapped) begin
					unique case (paddr)
						FSQ_OFF_CTRL: begin
							d.pgm   = pwdata[FSQ_CTRL_PGM];
							d.cfg   = pwdata[FSQ_CTRL_CFG];
							d.program_write_enable  = pwdata[FSQ_CTRL_PROGRAM_WRITE_ENABLE];
							d.erase = pwdata[FSQ_CTRL_ERASE];
							if (pwdata[FSQ_CTRL_ERR] == 1'b0) begin
								d.err = 1'b0;
							end
							d.key = FSQ_KEY_NONE;
							// start needs enable, program space and fresh key
							if (pwdata[FSQ_CTRL_START] && pwdata[FSQ_CTRL_PROGRAM_WRITE_ENABLE] &&
							    pwdata[FSQ_CTRL_PGM] && !pwdata[FSQ_CTRL_CFG] &&
							    q.key == FSQ_KEY_ARMED) begin // [R7] [R23]
								d.start   = 1'b1;
								d.cnt     = '0;
								d.idx     = '0;
								d.ops_done = 1'b0;
								// erase select chooses erase, else program
								d.state   = pwdata[FSQ_CTRL_ERASE] ? FSQ_ERASE : FSQ_PROG; // [R24]
							end else if (pwdata[FSQ_CTRL_START]) begin
								d.err = 1'b1; // [R23]
							end
						end
						FSQ_OFF_KEY: begin
							if (pwdata[7:0] == FSQ_KEY_FIRST) begin
								d.key = FSQ_KEY_HALF;
							end else if (pwdata[7:0] == FSQ_KEY_SECOND && q.key == FSQ_KEY_HALF) begin
								d.key = FSQ_KEY_ARMED; // [R7]
							end else begin
								d.key = FSQ_KEY_NONE;
							end
						end
						FSQ_OFF_PTR: begin
							d.ptr = pwdata[FSQ_PTR_W-1:0];
							d.key = FSQ_KEY_NONE;
						end
						FSQ_OFF_LATCH: begin
							d.latch = pwdata[7:0];
							d.key   = FSQ_KEY_NONE;
						end
						FSQ_OFF_TBLOP: begin
							d.key = FSQ_KEY_NONE;
							// bit 2 set: table write into holding, else no holding register is written
							if (pwdata[1:0] == FSQ_OP_PREINC) begin
								d.ptr = ptr_inc; // [R22]
								hsel  = ptr_inc[IDX_W-1:0];
							end else begin
								hsel  = q.ptr[IDX_W-1:0]; // [R20]
							end
							if (pwdata[2]) begin
								d.hold[hsel] = q.latch; // [R11] [R20]
							end
							if (pwdata[1:0] == FSQ_OP_POSTINC) begin
								d.ptr = ptr_inc; // [R22]
							end else if (pwdata[1:0] == FSQ_OP_POSTDEC) begin
								d.ptr = ptr_dec; // [R22]
							end
						end
						default: begin
							d.key = FSQ_KEY_NONE;
						end
					endcase
				end else if (rd_acc) begin
					unique case (paddr)
						FSQ_OFF_CTRL:   d.rdata = {26'h000_0000, q.err, q.pgm, q.cfg,
									  q.erase, q.program_write_enable, q.start};
						FSQ_OFF_PTR:    d.rdata = {10'h000, q.ptr};
						FSQ_OFF_LATCH:  d.rdata = {24'h00_0000, q.latch};
						FSQ_OFF_STATUS: d.rdata = {30'h0000_0000, q.start, cpu_stall};
						default:        d.rdata = 32'h0000_0000;
					endcase
				end
			end
			FSQ_ERASE: begin
				// one 64 byte block, pointer bits 5:0 forced to zero
				if (!q.ops_done && !flash_busy) begin
					d.cmd.req   = 1'b1; // [R1] [R2] [R4]
					d.cmd.erase = 1'b1;
					d.cmd.addr  = {q.ptr[21:FSQ_ERASE_LSB], 6'h00}; // [R3] [R4]
					d.cmd.wdata = FSQ_HOLD_RESET;
					d.cmd.bmask = '0;
					d.ops_done  = 1'b1;
				end
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == LONG_LAST) begin
					d.state = FSQ_DONE; // [R8] [R9]
				end
			end
			FSQ_PROG: begin
				// each byte goes out in turn; FFh bytes are skipped
				if (!q.ops_done && !flash_busy) begin
					if (q.hold[q.idx[IDX_W-1:0]] != FSQ_HOLD_RESET) begin // [R15] [R16]
						d.cmd.req   = 1'b1; // [R12]
						d.cmd.erase = 1'b0;
						d.cmd.addr  = {q.ptr[21:IDX_W], q.idx[IDX_W-1:0]}; // [R21]
						d.cmd.wdata = q.hold[q.idx[IDX_W-1:0]];
						d.cmd.bmask = 16'h0000;
					end
					d.idx = q.idx + 1'b1;
					if (q.idx == (IDX_W+1)'(BLOCK_BYTES - 1)) begin
						d.ops_done = 1'b1; // [R10]
					end
				end
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == LONG_LAST) begin
					d.state = FSQ_DONE; // [R8] [R13] [R19]
				end
			end
			FSQ_DONE: begin
				d.start = 1'b0;
				d.hold  = {BLOCK_BYTES{FSQ_HOLD_RESET}}; // [R14]
				d.state = FSQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q       <= '0;
			q.state <= FSQ_IDLE;
			q.key   <= FSQ_KEY_NONE;
			q.hold  <= {BLOCK_BYTES{FSQ_HOLD_RESET}}; // [R14]
		end else begin
			q <= d;
		end
	end
endmodule

/* fsq_sequencer_test.sv */
// self-checking bench for the flash sequencer
`timescale 1ns/10ps
module fsq_sequencer_test
	import fsq_pkg::*;
;
	logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, rd_pend = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rs = 32'h0000_7b4a, prdata;
	logic pready, pslverr, flash_busy, cpu_stall;
	fsq_flash_cmd_t flash_cmd;
	logic [30:0] ex_q[$];
	logic [31:0] rd_q[$];
	logic [7:0] hold[16];
	logic [21:0] base;
	int mismatches = 0, n_tests = 0, cyc = 0, k;
	always #25 core_clk = ~core_clk;
	fsq_sequencer #(.LONG_CYC(50)) i_fsq_sequencer (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .flash_busy, .flash_cmd, .cpu_stall);
	fsq_flash_model i_fsq_flash_model (.core_clk, .rst_b, .flash_cmd, .flash_busy);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic complete_run;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (!ok) begin
			mismatches++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		chk(pslverr === (a > FSQ_OFF_STATUS), "slverr");
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		apb(0, a, 0);
	endtask
	task automatic start(input logic [31:0] c);
		apb(1, FSQ_OFF_KEY, {24'h00_0000, FSQ_KEY_FIRST});
		apb(1, FSQ_OFF_KEY, {24'h00_0000, FSQ_KEY_SECOND});
		apb(1, FSQ_OFF_CTRL, c);
		rd(FSQ_OFF_STATUS, 0);
	endtask
	// result watcher: read data one cycle after access, flash commands
	always @(posedge core_clk) begin
		if (rd_pend) chk(prdata === rd_q.pop_front(), "read data");
		rd_pend = psel && penable && pready && !pwrite && paddr <= FSQ_OFF_STATUS;
		if (rst_b && flash_cmd.req)
			chk(ex_q.size() > 0 && {flash_cmd.erase, flash_cmd.addr, flash_cmd.erase ? 8'h00 : flash_cmd.wdata}
				=== ex_q.pop_front(), "flash cmd");
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		foreach (hold[i]) hold[i] = FSQ_HOLD_RESET;
		repeat (5) @(posedge core_clk);
		rst_b <= 1;
		@(posedge core_clk);
		apb(0, 8'h20, 0);
		apb(1, FSQ_OFF_CTRL, 32'h0000_0013);
		rd(FSQ_OFF_CTRL, 32'h0000_0032);
		apb(1, FSQ_OFF_CTRL, 0);
		start(32'h0000_0011);
		rd(FSQ_OFF_CTRL, 32'h0000_0030);
		apb(1, FSQ_OFF_CTRL, 0);
		apb(1, FSQ_OFF_KEY, {24'h00_0000, FSQ_KEY_FIRST});
		apb(1, FSQ_OFF_KEY, {24'h00_0000, FSQ_KEY_SECOND});
		apb(1, FSQ_OFF_PTR, 0);
		apb(1, FSQ_OFF_CTRL, 32'h0000_0013);
		rd(FSQ_OFF_CTRL, 32'h0000_0032);
		rd(FSQ_OFF_STATUS, 0);
		apb(1, FSQ_OFF_CTRL, 0);
		$display("refused starts done");
		rs = xs(rs);
		apb(1, FSQ_OFF_PTR, {10'h000, rs[21:0]});
		ex_q.push_back({1'b1, rs[21:6], 6'h00, 8'h00});
		start(32'h0000_0017);
		$display("erase done");
		rs = xs(rs);
		base = {rs[21:4], 4'h0};
		for (int m = 0; m < 4; m++) begin
			k = 2 * m + (m == 3);
			rs = xs(rs);
			hold[k] = rs[7:0] & 8'h7F;
			apb(1, FSQ_OFF_PTR, {10'h000, base + 22'(2 * m)});
			apb(1, FSQ_OFF_LATCH, {24'h00_0000, hold[k]});
			apb(1, FSQ_OFF_TBLOP, 32'h0000_0004 | m);
			rd(FSQ_OFF_PTR, {10'h000, base + 22'(2 * m + (m == 0 ? 0 : m == 2 ? -1 : 1))});
		end
		for (int i = 0; i < 16; i++)
			if (hold[i] !== FSQ_HOLD_RESET) ex_q.push_back({1'b0, base[21:4], 4'(i), hold[i]});
		start(32'h0000_0013);
		start(32'h0000_0013);
		chk(ex_q.size() == 0, "missing cmd");
		$display("program done");
		complete_run();
	end
endmodule
